// ---- design/pbo_params.svh ----
`ifndef PBO_PARAMS_SVH
`define PBO_PARAMS_SVH
`define PBO_BIT_SS 0
`define PBO_BIT_SCK 1
`define PBO_BIT_MOSI 2
`define PBO_BIT_MISO 3
`define PBO_SEG_PC_BASE 5
`define PBO_SEG_PD_BASE 15
`define PBO_RST_BYTE 8'h00
`endif

// ---- design/pbo_pkg.sv ----
package pbo_pkg;
  typedef logic [7:0] pbo_byte_t;
  typedef struct packed {
    logic pu_en;
    logic pu_val;
    logic dd_en;
    logic dd_val;
    logic pv_en;
    logic pv_val;
    logic die_en;
    logic die_val;
  } pbo_ovr_t;
endpackage : pbo_pkg

// ---- design/pbo_pin_resolve.sv ----
`include "pbo_params.svh"
// Applies override signals to one port's direction, value, pull-up and input enable
module pbo_pin_resolve (
  // Port register bits
  input wire logic [7:0] dir_in,
  input wire logic [7:0] latch_in,
  input wire logic global_pullup_disable_in,
  // Override enables and values
  input wire logic [7:0] pu_en_in,
  input wire logic [7:0] pu_val_in,
  input wire logic [7:0] dd_en_in,
  input wire logic [7:0] dd_val_in,
  input wire logic [7:0] pv_en_in,
  input wire logic [7:0] pv_val_in,
  input wire logic [7:0] die_en_in,
  input wire logic [7:0] die_val_in,
  // Resolved pad controls
  output logic [7:0] oe_out,
  output logic [7:0] val_out,
  output logic [7:0] pullup_out,
  output logic [7:0] din_en_out
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      oe_out[i] = dd_en_in[i] ? dd_val_in[i] : dir_in[i];
      val_out[i] = pv_en_in[i] ? pv_val_in[i] : latch_in[i];
      // Normal pull-up: input direction, latch high, not globally disabled
      pullup_out[i] = pu_en_in[i] ? pu_val_in[i]
                    : (~dir_in[i] & latch_in[i] & ~global_pullup_disable_in);
      din_en_out[i] = die_en_in[i] ? die_val_in[i] : 1'b1;
    end
  end
endmodule : pbo_pin_resolve

// ---- design/pbo_port_override.sv ----
// global disable.
`include "pbo_params.svh"
module pbo_port_override
  import pbo_pkg::*;
(
  // Clock and control
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic CE_IN,
  // Port B registers
  input wire pbo_pkg::pbo_byte_t DIR_B_IN,
  input wire pbo_pkg::pbo_byte_t LATCH_B_IN,
  input wire pbo_pkg::pbo_byte_t PIN_CHANGE_MASK_B_IN,
  input wire logic PIN_CHANGE_GROUP1_ENABLE_IN,
  input wire logic GLOBAL_PULLUP_DISABLE_IN,
  // Port C registers
  input wire pbo_pkg::pbo_byte_t DIR_C_IN,
  input wire pbo_pkg::pbo_byte_t LATCH_C_IN,
  // SPI
  input wire logic SPI_ENABLE_BIT_IN,
  input wire logic SPI_MASTER_SELECT_IN,
  input wire logic SPI_SLAVE_OUTPUT_IN,
  input wire logic SPI_MASTER_OUTPUT_IN,
  input wire logic SPI_CLOCK_OUTPUT_IN,
  // Timer compare
  input wire logic [3:0] TIMER_COMPARE_EN_IN,
  input wire logic TIMER2_COMPARE_A_OUT_IN,
  input wire logic TIMER1_COMPARE_B_OUT_IN,
  input wire logic TIMER1_COMPARE_A_OUT_IN,
  input wire logic TIMER0_COMPARE_A_OUT_IN,
  // LCD
  input wire logic LCD_ENABLE_IN,
  input wire logic [22:0] LCD_SEGMENT_IN,
  // Pads (asynchronous)
  input wire pbo_pkg::pbo_byte_t PAD_B_IN,
  input wire pbo_pkg::pbo_byte_t PAD_C_IN,
  input wire pbo_pkg::pbo_byte_t PAD_D_IN,
  // Port B pad controls
  output pbo_pkg::pbo_byte_t PAD_B_OE_OUT,
  output pbo_pkg::pbo_byte_t PAD_B_VAL_OUT,
  output pbo_pkg::pbo_byte_t PAD_B_PULLUP_OUT,
  output pbo_pkg::pbo_byte_t PAD_B_DIN_EN_OUT,
  // Port C pad controls
  output pbo_pkg::pbo_byte_t PAD_C_OE_OUT,
  output pbo_pkg::pbo_byte_t PAD_C_VAL_OUT,
  output pbo_pkg::pbo_byte_t PAD_C_PULLUP_OUT,
  output pbo_pkg::pbo_byte_t PAD_C_DIN_EN_OUT,
  output pbo_pkg::pbo_byte_t PAD_C_LCD_SEG_OUT,
  output logic PAD_C_LCD_CONNECT_OUT,
  // Port D analog routing
  output logic [7:0] PAD_D_LCD_SEG_OUT,
  // Peripheral inputs
  output pbo_pkg::pbo_byte_t PIN_CHANGE_INPUT_OUT,
  output logic SPI_MASTER_INPUT_OUT,
  output logic SPI_SLAVE_INPUT_OUT,
  output logic SPI_CLOCK_INPUT_OUT,
  output logic SPI_SELECT_INPUT_OUT,
  output logic SPI_SLAVE_ACTIVE_OUT,
  output logic EXT_IRQ0_INPUT_OUT,
  output logic TIMER1_CAPTURE_INPUT_OUT
);
  import pbo_pkg::*;

  function automatic logic [7:0] pbo_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : pbo_rev8

  // Pad sampling: two flops before any logic reads the pads
  pbo_byte_t b_s1_q, b_s2_q, c_s1_q, c_s2_q, d_s1_q, d_s2_q;
  pbo_byte_t b_s1_d, b_s2_d, c_s1_d, c_s2_d, d_s1_d, d_s2_d;

  always_comb begin
    b_s1_d = PAD_B_IN;
    b_s2_d = b_s1_q;
    c_s1_d = PAD_C_IN;
    c_s2_d = c_s1_q;
    d_s1_d = PAD_D_IN;
    d_s2_d = d_s1_q;
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      b_s1_q <= `PBO_RST_BYTE;
      b_s2_q <= `PBO_RST_BYTE;
      c_s1_q <= `PBO_RST_BYTE;
      c_s2_q <= `PBO_RST_BYTE;
      d_s1_q <= `PBO_RST_BYTE;
      d_s2_q <= `PBO_RST_BYTE;
    end else if (CE_IN) begin
      b_s1_q <= b_s1_d;
      b_s2_q <= b_s2_d;
      c_s1_q <= c_s1_d;
      c_s2_q <= c_s2_d;
      d_s1_q <= d_s1_d;
      d_s2_q <= d_s2_d;
    end
  end

  // Port B override signals
  logic spi_slave, spi_master;
  pbo_byte_t b_pu_en, b_pu_val, b_dd_en, b_dd_val, b_pv_en, b_pv_val, b_die_en, b_die_val;
  pbo_byte_t c_en, c_zero;

  always_comb begin
    spi_slave = SPI_ENABLE_BIT_IN & ~SPI_MASTER_SELECT_IN;
    spi_master = SPI_ENABLE_BIT_IN & SPI_MASTER_SELECT_IN;
    b_pu_en = '0;
    b_pu_val = '0;
    b_dd_en = '0;
    b_dd_val = '0;
    b_pv_en = '0;
    b_pv_val = '0;
    // Forced inputs keep latch pull-up unless globally disabled
    for (int i = 0; i < 3; i++) begin
      b_pu_en[i] = spi_slave;
      b_pu_val[i] = LATCH_B_IN[i] & ~GLOBAL_PULLUP_DISABLE_IN;
      b_dd_en[i] = spi_slave;
    end
    b_pu_en[`PBO_BIT_MISO] = spi_master;
    b_pu_val[`PBO_BIT_MISO] = LATCH_B_IN[`PBO_BIT_MISO] & ~GLOBAL_PULLUP_DISABLE_IN;
    b_dd_en[`PBO_BIT_MISO] = spi_master;
    // Slave drives out B3 and master drives B2 and B1, each only if its direction bit allows
    b_pv_en[`PBO_BIT_MISO] = spi_slave;
    b_pv_val[`PBO_BIT_MISO] = SPI_SLAVE_OUTPUT_IN;
    b_pv_en[`PBO_BIT_MOSI] = spi_master;
    b_pv_val[`PBO_BIT_MOSI] = SPI_MASTER_OUTPUT_IN;
    b_pv_en[`PBO_BIT_SCK] = spi_master;
    b_pv_val[`PBO_BIT_SCK] = SPI_CLOCK_OUTPUT_IN;
    b_pv_en[7:4] = TIMER_COMPARE_EN_IN;
    b_pv_val[7:4] = {TIMER2_COMPARE_A_OUT_IN, TIMER1_COMPARE_B_OUT_IN,
                     TIMER1_COMPARE_A_OUT_IN, TIMER0_COMPARE_A_OUT_IN};
    b_die_en = PIN_CHANGE_MASK_B_IN & {8{PIN_CHANGE_GROUP1_ENABLE_IN}};
    b_die_val = 8'hFF;
    c_en = {8{LCD_ENABLE_IN}};
    c_zero = 8'h00;
  end

  pbo_byte_t b_oe, b_val, b_pu, b_die, c_oe, c_val, c_pu, c_die;

  pbo_pin_resolve u_port_b (
    .dir_in(DIR_B_IN),
    .latch_in(LATCH_B_IN),
    .global_pullup_disable_in(GLOBAL_PULLUP_DISABLE_IN),
    .pu_en_in(b_pu_en),
    .pu_val_in(b_pu_val),
    .dd_en_in(b_dd_en),
    .dd_val_in(b_dd_val),
    .pv_en_in(b_pv_en),
    .pv_val_in(b_pv_val),
    .die_en_in(b_die_en),
    .die_val_in(b_die_val),
    .oe_out(b_oe),
    .val_out(b_val),
    .pullup_out(b_pu),
    .din_en_out(b_die)
  );

  // Port C: LCD forces pull-up off, input direction and digital input off
  pbo_pin_resolve u_port_c (
    .dir_in(DIR_C_IN),
    .latch_in(LATCH_C_IN),
    .global_pullup_disable_in(GLOBAL_PULLUP_DISABLE_IN),
    .pu_en_in(c_en),
    .pu_val_in(c_zero),
    .dd_en_in(c_en),
    .dd_val_in(c_zero),
    .pv_en_in(c_zero),
    .pv_val_in(c_zero),
    .die_en_in(c_en),
    .die_val_in(c_zero),
    .oe_out(c_oe),
    .val_out(c_val),
    .pullup_out(c_pu),
    .din_en_out(c_die)
  );

  // Registered outputs; pad controls lag their causes by one cycle
  pbo_byte_t b_oe_q, b_val_q, b_pu_q, b_die_q, c_oe_q, c_val_q, c_pu_q, c_die_q, c_seg_q;
  pbo_byte_t pcint_q, pcint_d, d_seg_q, d_seg_d, c_seg_d;
  logic [6:0] spi_q, spi_d;
  logic c_conn_q;

  always_comb begin
    // Digital input gated by its enable so a disabled pin reads low
    pcint_d = b_s2_q & b_die;
    spi_d[0] = b_s2_q[`PBO_BIT_MISO];
    spi_d[1] = b_s2_q[`PBO_BIT_MOSI];
    spi_d[2] = b_s2_q[`PBO_BIT_SCK];
    spi_d[3] = b_s2_q[`PBO_BIT_SS];
    spi_d[4] = spi_slave & ~b_s2_q[`PBO_BIT_SS];
    spi_d[5] = d_s2_q[1];
    spi_d[6] = d_s2_q[0];
    c_seg_d = pbo_rev8(LCD_SEGMENT_IN[`PBO_SEG_PC_BASE +: 8]);
    d_seg_d = pbo_rev8(LCD_SEGMENT_IN[`PBO_SEG_PD_BASE +: 8]);
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      b_oe_q <= `PBO_RST_BYTE;
      b_val_q <= `PBO_RST_BYTE;
      b_pu_q <= `PBO_RST_BYTE;
      b_die_q <= `PBO_RST_BYTE;
      c_oe_q <= `PBO_RST_BYTE;
      c_val_q <= `PBO_RST_BYTE;
      c_pu_q <= `PBO_RST_BYTE;
      c_die_q <= `PBO_RST_BYTE;
      c_seg_q <= `PBO_RST_BYTE;
      d_seg_q <= `PBO_RST_BYTE;
      pcint_q <= `PBO_RST_BYTE;
      spi_q <= 7'h00;
      c_conn_q <= 1'b0;
    end else if (CE_IN) begin
      b_oe_q <= b_oe;
      b_val_q <= b_val;
      b_pu_q <= b_pu;
      b_die_q <= b_die;
      c_oe_q <= c_oe;
      c_val_q <= c_val;
      c_pu_q <= c_pu;
      c_die_q <= c_die;
      c_seg_q <= c_seg_d;
      d_seg_q <= d_seg_d;
      pcint_q <= pcint_d;
      spi_q <= spi_d;
      c_conn_q <= LCD_ENABLE_IN;
    end
  end

  assign PAD_B_OE_OUT = b_oe_q;
  assign PAD_B_VAL_OUT = b_val_q;
  assign PAD_B_PULLUP_OUT = b_pu_q;
  assign PAD_B_DIN_EN_OUT = b_die_q;
  assign PAD_C_OE_OUT = c_oe_q;
  assign PAD_C_VAL_OUT = c_val_q;
  assign PAD_C_PULLUP_OUT = c_pu_q;
  assign PAD_C_DIN_EN_OUT = c_die_q;
  assign PAD_C_LCD_SEG_OUT = c_seg_q;
  assign PAD_C_LCD_CONNECT_OUT = c_conn_q;
  assign PAD_D_LCD_SEG_OUT = d_seg_q;
  assign PIN_CHANGE_INPUT_OUT = pcint_q;
  assign SPI_MASTER_INPUT_OUT = spi_q[0];
  assign SPI_SLAVE_INPUT_OUT = spi_q[1];
  assign SPI_CLOCK_INPUT_OUT = spi_q[2];
  assign SPI_SELECT_INPUT_OUT = spi_q[3];
  assign SPI_SLAVE_ACTIVE_OUT = spi_q[4];
  assign EXT_IRQ0_INPUT_OUT = spi_q[5];
  assign TIMER1_CAPTURE_INPUT_OUT = spi_q[6];
endmodule : pbo_port_override

// ---- verif/pbo_port_override_assertions.sv ----
module pbo_port_override_chk
  import pbo_pkg::*;
(
  // Controls
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic CE_IN,
  input wire logic [7:0] DIR_B_IN,
  input wire logic [7:0] LATCH_B_IN,
  input wire logic PIN_CHANGE_GROUP1_ENABLE_IN,
  input wire logic GLOBAL_PULLUP_DISABLE_IN,
  input wire logic SPI_ENABLE_BIT_IN,
  input wire logic SPI_MASTER_SELECT_IN,
  input wire logic SPI_MASTER_OUTPUT_IN,
  input wire logic SPI_CLOCK_OUTPUT_IN,
  input wire logic LCD_ENABLE_IN,
  input wire logic [22:0] LCD_SEGMENT_IN,
  // Pad results
  input wire logic [7:0] PAD_B_OE_OUT,
  input wire logic [7:0] PAD_B_VAL_OUT,
  input wire logic [7:0] PAD_B_PULLUP_OUT,
  input wire logic [7:0] PAD_B_DIN_EN_OUT,
  input wire logic [7:0] PAD_C_OE_OUT,
  input wire logic [7:0] PAD_C_PULLUP_OUT,
  input wire logic [7:0] PAD_C_DIN_EN_OUT,
  input wire logic [7:0] PAD_C_LCD_SEG_OUT,
  input wire logic PAD_C_LCD_CONNECT_OUT,
  input wire logic [7:0] PAD_D_LCD_SEG_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slv, mas;
  logic [7:0] fpu, rc, rd;
  assign slv = CE_IN & SPI_ENABLE_BIT_IN & ~SPI_MASTER_SELECT_IN;
  assign mas = CE_IN & SPI_ENABLE_BIT_IN & SPI_MASTER_SELECT_IN;
  // A forced input still takes its pull-up from the latch
  assign fpu = LATCH_B_IN & ~{8{GLOBAL_PULLUP_DISABLE_IN}};
  assign rc = {<<{LCD_SEGMENT_IN[12:5]}};
  assign rd = {<<{LCD_SEGMENT_IN[22:15]}};
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  slave_dir_a: assert property (slv |=> PAD_B_OE_OUT[2:0] == 3'h0)
    else $error("slave pin still driving");
  slave_pullup_a: assert property (slv |=> PAD_B_PULLUP_OUT[2:0] == $past(fpu[2:0]))
    else $error("slave pull-up wrong");
  master_dir_a: assert property (
    mas |=> !PAD_B_OE_OUT[3] && PAD_B_OE_OUT[2:0] == $past(DIR_B_IN[2:0]))
    else $error("master direction wrong");
  master_val_a: assert property (
    mas |=> PAD_B_VAL_OUT[2:1] == {$past(SPI_MASTER_OUTPUT_IN), $past(SPI_CLOCK_OUTPUT_IN)})
    else $error("master value wrong");
  din_force_a: assert property (
    CE_IN && PIN_CHANGE_GROUP1_ENABLE_IN |=> PAD_B_DIN_EN_OUT == 8'hFF)
    else $error("pin-change input off");
  lcd_takeover_a: assert property (
    CE_IN && LCD_ENABLE_IN |=> PAD_C_LCD_CONNECT_OUT
      && (PAD_C_OE_OUT | PAD_C_PULLUP_OUT | PAD_C_DIN_EN_OUT) == 8'h00)
    else $error("display pins not released");
  seg_c_a: assert property (CE_IN |=> PAD_C_LCD_SEG_OUT == $past(rc))
    else $error("port C segment order wrong");
  seg_d_a: assert property (CE_IN |=> PAD_D_LCD_SEG_OUT == $past(rd))
    else $error("port D segment order wrong");
endmodule : pbo_port_override_chk
bind pbo_port_override pbo_port_override_chk u_chk (.*);

// ---- verif/pbo_periph_model.sv ----
module pbo_periph_model (
  // Clock and mode
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic master_in,
  input wire logic active_in,
  // Clock, data, compare and segment drive
  output logic [29:0] drv_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lfsr = 16'hACE1;
  logic hold = 1'b0;
  initial drv_out = 30'h0;
  always @(posedge clk_in) begin
    hold <= slow_in & ~hold;
    if (!hold) begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      // Clock stands still outside a master frame
      drv_out[29] <= master_in & ~drv_out[29];
      drv_out[28] <= lfsr[0];
      // A released slave output must not look like held data
      drv_out[27] <= active_in ? lfsr[1] : ~drv_out[27];
      drv_out[26:0] <= {lfsr[10:0], lfsr};
    end
  end
endmodule : pbo_periph_model

// ---- verif/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pbo_pkg::*;
  logic CLK_IN = 1'b0, SRST_IN = 1'b1, CE_IN = 1'b1, slow = 1'b0;
  pbo_byte_t DIR_B_IN = '0, LATCH_B_IN = '0, PIN_CHANGE_MASK_B_IN = '0, DIR_C_IN = '0;
  pbo_byte_t LATCH_C_IN = '0, PAD_B_IN = '0, PAD_C_IN = '0, PAD_D_IN = '0;
  logic PIN_CHANGE_GROUP1_ENABLE_IN = 1'b0, GLOBAL_PULLUP_DISABLE_IN = 1'b0;
  logic LCD_ENABLE_IN = 1'b0, SPI_ENABLE_BIT_IN = 1'b0, SPI_MASTER_SELECT_IN = 1'b0;
  logic [3:0] TIMER_COMPARE_EN_IN = '0;
  logic SPI_SLAVE_OUTPUT_IN, SPI_MASTER_OUTPUT_IN, SPI_CLOCK_OUTPUT_IN;
  logic TIMER2_COMPARE_A_OUT_IN, TIMER1_COMPARE_B_OUT_IN, TIMER1_COMPARE_A_OUT_IN;
  logic TIMER0_COMPARE_A_OUT_IN;
  logic [22:0] LCD_SEGMENT_IN;
  pbo_byte_t PAD_B_OE_OUT, PAD_B_VAL_OUT, PAD_B_PULLUP_OUT, PAD_B_DIN_EN_OUT, PAD_C_OE_OUT;
  pbo_byte_t PAD_C_VAL_OUT, PAD_C_PULLUP_OUT, PAD_C_DIN_EN_OUT, PAD_C_LCD_SEG_OUT;
  pbo_byte_t PAD_D_LCD_SEG_OUT, PIN_CHANGE_INPUT_OUT;
  logic PAD_C_LCD_CONNECT_OUT, SPI_MASTER_INPUT_OUT, SPI_SLAVE_INPUT_OUT, SPI_CLOCK_INPUT_OUT;
  logic SPI_SELECT_INPUT_OUT, SPI_SLAVE_ACTIVE_OUT, EXT_IRQ0_INPUT_OUT, TIMER1_CAPTURE_INPUT_OUT;
  logic [29:0] drv, smp;
  logic [31:0] r;
  logic [15:0] s1, s2;
  logic [7:0] eb;
  pbo_byte_t e [11];
  int seed = 48, miscompares = 0, checks = 0, warm = 0;
  assign {SPI_CLOCK_OUTPUT_IN, SPI_MASTER_OUTPUT_IN, SPI_SLAVE_OUTPUT_IN, TIMER2_COMPARE_A_OUT_IN,
    TIMER1_COMPARE_B_OUT_IN, TIMER1_COMPARE_A_OUT_IN, TIMER0_COMPARE_A_OUT_IN, LCD_SEGMENT_IN} = drv;
  pbo_port_override dut (.*);
  pbo_periph_model peer (.clk_in(CLK_IN), .slow_in(slow), .drv_out(drv),
    .master_in(SPI_ENABLE_BIT_IN & SPI_MASTER_SELECT_IN), .active_in(SPI_SLAVE_ACTIVE_OUT));
  always #50 CLK_IN = ~CLK_IN;
  // What the block saw from the peripherals at the last edge
  always @(posedge CLK_IN) smp <= drv;
  task automatic chk_byte(input pbo_byte_t gv, input pbo_byte_t ev);
    checks++;
    if (gv !== ev) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic gv, input logic ev);
    chk_byte({7'h00, gv}, {7'h00, ev});
  endtask : chk_bit
  function automatic void model();
    logic slv;
    pbo_byte_t fpu;
    slv = SPI_ENABLE_BIT_IN & ~SPI_MASTER_SELECT_IN;
    fpu = LATCH_B_IN & ~{8{GLOBAL_PULLUP_DISABLE_IN}};
    if (SRST_IN) begin
      e = '{default: 8'h00};
      eb = 8'h00;
      warm = 0;
    end else if (CE_IN) begin
      e[0] = DIR_B_IN;
      e[1] = LATCH_B_IN;
      e[2] = fpu & ~DIR_B_IN;
      if (slv) begin
        e[0][2:0] = 3'h0;
        e[2][2:0] = fpu[2:0];
        e[1][3] = smp[27];
      end
      if (SPI_ENABLE_BIT_IN && SPI_MASTER_SELECT_IN) begin
        e[0][3] = 1'b0;
        e[2][3] = fpu[3];
        // Data-out pin carries the master output, clock pin the SPI clock
        e[1][2:1] = {smp[28], smp[29]};
      end
      for (int i = 0; i < 4; i++) if (TIMER_COMPARE_EN_IN[i]) e[1][4+i] = smp[23+i];
      e[3] = 8'hFF;
      e[4] = LCD_ENABLE_IN ? 8'h00 : DIR_C_IN;
      e[5] = LATCH_C_IN;
      e[6] = LATCH_C_IN & ~(DIR_C_IN | {8{LCD_ENABLE_IN | GLOBAL_PULLUP_DISABLE_IN}});
      e[7] = {8{~LCD_ENABLE_IN}};
      e[8] = {<<{smp[12:5]}};
      e[9] = {<<{smp[22:15]}};
      e[10] = s2[7:0];
      eb = {LCD_ENABLE_IN, slv & ~s2[0], s2[9:8], s2[3:0]};
      s2 = s1;
      s1 = {PAD_D_IN, PAD_B_IN};
      warm++;
    end
  endfunction : model
  task automatic summarize;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  initial begin
    for (int it = 0; it < 2000; it++) begin
      @(negedge CLK_IN);
      model();
      chk_byte(PAD_B_OE_OUT, e[0]);
      chk_byte(PAD_B_VAL_OUT, e[1]);
      chk_byte(PAD_B_PULLUP_OUT, e[2]);
      chk_byte(PAD_B_DIN_EN_OUT, e[3]);
      chk_byte(PAD_C_OE_OUT, e[4]);
      chk_byte(PAD_C_VAL_OUT, e[5]);
      chk_byte(PAD_C_PULLUP_OUT, e[6]);
      chk_byte(PAD_C_DIN_EN_OUT, e[7]);
      chk_byte(PAD_C_LCD_SEG_OUT, e[8]);
      chk_byte(PAD_D_LCD_SEG_OUT, e[9]);
      chk_bit(PAD_C_LCD_CONNECT_OUT, eb[7]);
      // Model pad pipeline s1/s2 holds stale values until refilled after reset
      if (warm >= 3) begin
        chk_byte(PIN_CHANGE_INPUT_OUT, e[10]);
        chk_bit(SPI_SLAVE_ACTIVE_OUT, eb[6]);
        chk_byte({2'h0, EXT_IRQ0_INPUT_OUT, TIMER1_CAPTURE_INPUT_OUT, SPI_MASTER_INPUT_OUT,
          SPI_SLAVE_INPUT_OUT, SPI_CLOCK_INPUT_OUT, SPI_SELECT_INPUT_OUT}, {2'h0, eb[5:0]});
      end
      r = $random(seed);
      SRST_IN = it < 9 || (it >= 1000 && it < 1003);
      CE_IN = SRST_IN || r[2:0] != 3'h0;
      {slow, TIMER_COMPARE_EN_IN, LCD_ENABLE_IN, GLOBAL_PULLUP_DISABLE_IN,
        PIN_CHANGE_GROUP1_ENABLE_IN} = r[15:8];
      {SPI_ENABLE_BIT_IN, SPI_MASTER_SELECT_IN} = 2'(it >> 6);
      {DIR_B_IN, LATCH_B_IN, PIN_CHANGE_MASK_B_IN, DIR_C_IN} = $random(seed);
      {LATCH_C_IN, PAD_B_IN, PAD_C_IN, PAD_D_IN} = $random(seed);
      // Output-set pins with latch high expose a forced input on the pull-up
      if (it % 16 == 0) {DIR_B_IN, LATCH_B_IN, GLOBAL_PULLUP_DISABLE_IN} = {16'hFFFF, 1'b0};
      if (it % 4 == 0) PAD_B_IN[0] = 1'b0;
    end
    summarize();
  end
  // Test needs 2000 cycles; allow a margin before declaring a hang
  initial begin
    #210000;
    miscompares++;
    summarize();
  end
endmodule : tb_top
